/* verilog/cmr_consts.vh */
// Constants of the capture/compare mode and timer routing block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef CMR_CONSTS_VH
`define CMR_CONSTS_VH

// ****************************************************************
// Register byte addresses on the APB.
// ****************************************************************
`define CMR_ENH_CTL   8'h00
`define CMR_STD_CTL   8'h04
`define CMR_ENH_DL    8'h08
`define CMR_ENH_DH    8'h0c
`define CMR_STD_DL    8'h10
`define CMR_STD_DH    8'h14
`define CMR_TC_CTL    8'h18
`define CMR_TC_LO     8'h1c
`define CMR_TC_HI     8'h20
`define CMR_STATUS    8'h24

// ****************************************************************
// Mode select codes.
// ****************************************************************
`define CMR_MODE_OFF  4'h0
`define CMR_MODE_RSVD 4'h1
`define CMR_CMP_TOG   4'h2
`define CMR_CAP_FALL  4'h4
`define CMR_CAP_RISE  4'h5
`define CMR_CAP_4TH   4'h6
`define CMR_CAP_16TH  4'h7
`define CMR_CMP_SET   4'h8
`define CMR_CMP_CLR   4'h9
`define CMR_CMP_SWI   4'ha
`define CMR_CMP_TRIG  4'hb

// ****************************************************************
// Field positions, masks, counts and reset values.
// ****************************************************************
`define CMR_CTL_MASK  8'h3f
`define CMR_ASG_HI    6
`define CMR_ASG_LO    3
`define CMR_ST_OVF    2
`define CMR_PRE_4TH   4'h3
`define CMR_PRE_16TH  4'hf
`define CMR_RST_BYTE  8'h00
`define CMR_RST_WORD  16'h0000
`define CMR_RST_DATA  32'h00000000

`endif

/* verilog/cmr_mode_routing.v */
// Mode control, data registers and timer routing of two capture/compare
// units (unit 0 enhanced, unit 1 standard), reached over APB.
// Assumes the timers and the A/D converter sit outside on pclk and
// present their counts and status synchronously; capture pins are async.
//
// Function
// - Enhanced trigger mode match resets its assigned timer.
// - Trigger starts A/D only when converter enabled.
// - Software timer C write beats trigger reset.
// - Trigger reset never sets timer C overflow flag.
// - Compare value acts as timer period.
// - Control bits 7-6 read zero, ignore writes.
// - PWM duty is data low byte plus two bits.
// - Mode 0000 disables and resets unit; 0001 reserved.
// - Mode 0010 toggles pin, sets flag on match.
// - Each unit has a 16-bit data register.
// - Data register accessed as two writable bytes.
// - Capture/compare use timer A or C; PWM base.
// - Timer C control assignment bits choose timers.
// - Both units active, may share a timer.
// - Two capture units may use different timers.
// - Either trigger resets; only enhanced starts A/D.
// - Both PWM units share one PWM base.
// - Assign 1x: C both; 01: C enh, A std; 00: A.
// - Trigger resets the unit's assigned timer.
//
// Design decisions made here: the APB interface to the registers and the register offsets.

`include "cmr_consts.vh"

module cmr_mode_routing (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [15:0] timer_a_count,
	input  wire [15:0] timer_c_count,
	input  wire [7:0]  pwm_base_count,
	input  wire        timer_c_overflow,
	input  wire        adc_enabled,
	input  wire [1:0]  capture_in,
	output wire [1:0]  unit_pin,
	output reg         timer_a_reset,
	output reg         timer_c_reset,
	output reg         timer_c_wr_low,
	output reg         timer_c_wr_high,
	output reg  [7:0]  timer_c_wr_data,
	output reg  [7:0]  timer_c_control,
	output reg         adc_start
);

	// ****************************************************************
	// Bus decode.
	// ****************************************************************

	// A write lands only on the completing access edge.
	wire        wr = psel & penable & pready & pwrite;
	wire        setup = psel & ~penable;
	wire        wr_st = wr & (paddr == `CMR_STATUS);
	wire        wr_tlo = wr & (paddr == `CMR_TC_LO);
	wire        wr_thi = wr & (paddr == `CMR_TC_HI);
	wire        tc_wr = wr_tlo | wr_thi;
	wire [15:0] ctl_w;
	wire [31:0] dat_w;
	wire [1:0]  flag_w;
	wire [1:0]  trig_w;
	wire [1:0]  use_c_w;
	reg         ovf_flag;
	reg  [31:0] next_prdata;
	reg         next_err;

	// Timer assignment decode: enhanced takes C on 1x or 01, standard on 1x.
	wire asg_hi = timer_c_control[`CMR_ASG_HI];
	wire asg_lo = timer_c_control[`CMR_ASG_LO];

	// ****************************************************************
	// Per-unit mode logic.
	// ****************************************************************
	genvar u;
	generate
		for (u = 0; u < 2; u = u + 1) begin : g_unit
			localparam [7:0] A_CTL = (u == 0) ? `CMR_ENH_CTL : `CMR_STD_CTL;
			localparam [7:0] A_DL = (u == 0) ? `CMR_ENH_DL : `CMR_STD_DL;
			localparam [7:0] A_DH = (u == 0) ? `CMR_ENH_DH : `CMR_STD_DH;

			reg  [7:0]  ctl;
			reg  [15:0] dat;
			reg         pin;
			reg         flag;
			reg         match_q;
			reg  [3:0]  pre;
			reg         s1;
			reg         s2;
			reg         s3;
			reg         lvl;

			wire [3:0]  md = ctl[3:0];
			wire        is_cmp = (md[3:2] == 2'b10) | (md == `CMR_CMP_TOG);
			wire        is_cap = (md[3:2] == 2'b01);
			wire        is_pwm = (md[3:2] == 2'b11);
			// Each unit picks its own timer, so two captures may differ.
			wire        use_c = (u == 0) ? (asg_hi | asg_lo) : asg_hi;
			// Capture and compare count on timer A or C only.
			wire [15:0] tb = use_c ? timer_c_count : timer_a_count;
			wire        hit = is_cmp & (tb == dat);
			// Only the first cycle of a match counts, since a slow timer
			// can sit on the compare value for many clocks.
			wire        evt = hit & ~match_q;
			// Three-stage sync; a level counts once stages two and three agree.
			wire        stable = (s2 == s3);
			wire        rise = stable & s3 & ~lvl;
			wire        fall = stable & ~s3 & lvl;
			wire        cap_edge = (md == `CMR_CAP_FALL) ? fall : rise;
			wire        pre_full = (md == `CMR_CAP_4TH) ? (pre == `CMR_PRE_4TH) :
				(md == `CMR_CAP_16TH) ? (pre == `CMR_PRE_16TH) : 1'b1;
			wire        cap_evt = is_cap & cap_edge & pre_full;
			// Ten-bit duty: data low byte on top, two control bits below.
			wire [9:0]  duty = {dat[7:0], ctl[5:4]};
			// Both units compare against the single shared PWM base.
			wire        pwm_lvl = ({pwm_base_count, 2'b00} < duty);

			assign ctl_w[8*u +: 8] = ctl;
			assign dat_w[16*u +: 16] = dat;
			assign flag_w[u] = flag;
			assign unit_pin[u] = pin;
			assign use_c_w[u] = use_c;
			assign trig_w[u] = evt & (md == `CMR_CMP_TRIG);

			// Control and data registers; a capture overrides a same-cycle
			// byte write so that no event is lost.
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctl <= `CMR_RST_BYTE;
					dat <= `CMR_RST_WORD;
				end else begin
					if (wr && paddr == A_CTL)
						ctl <= pwdata[7:0] & `CMR_CTL_MASK;
					if (cap_evt)
						dat <= tb;
					else begin
						if (wr && paddr == A_DL)
							dat[7:0] <= pwdata[7:0];
						if (wr && paddr == A_DH)
							dat[15:8] <= pwdata[7:0];
					end
				end
			end

			// Pin synchroniser and capture prescaler.
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					lvl <= 1'b0;
					pre <= 4'h0;
				end else begin
					s1 <= capture_in[u];
					s2 <= s1;
					s3 <= s2;
					if (stable)
						lvl <= s3;
					// Prescaler clears whenever the unit is not capturing.
					if (!is_cap)
						pre <= 4'h0;
					else if (cap_edge)
						pre <= cap_evt ? 4'h0 : pre + 4'h1;
				end
			end

			// Output pin, match history and interrupt flag.
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin <= 1'b0;
					match_q <= 1'b0;
					flag <= 1'b0;
				end else begin
					match_q <= hit;
					// Mode off parks the pin low; reserved code does nothing.
					if (md == `CMR_MODE_OFF)
						pin <= 1'b0;
					else if (is_pwm)
						pin <= pwm_lvl;
					else if (evt) begin
						case (md)
							`CMR_CMP_TOG: pin <= ~pin;
							`CMR_CMP_SET: pin <= 1'b1;
							`CMR_CMP_CLR: pin <= 1'b0;
							default: pin <= pin;
						endcase
					end
					// Set beats a same-cycle write-one-to-clear.
					if (evt || cap_evt)
						flag <= 1'b1;
					else if (wr_st && pwdata[u])
						flag <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Trigger routing to timers and A/D.
	// ****************************************************************

	// A trigger resets whichever timer its unit is assigned to.
	wire trig_a = |(trig_w & ~use_c_w);
	wire trig_c = |(trig_w & use_c_w);

	// Registered pulses, one cycle each; the timer C reset is dropped
	// when software loads the timer in the same cycle. The timer must
	// count synchronously to pclk for the reset to land.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_a_reset <= 1'b0;
			timer_c_reset <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			timer_a_reset <= trig_a;
			timer_c_reset <= trig_c & ~tc_wr;
			adc_start <= trig_w[0] & adc_enabled;
		end
	end

	// Timer C control and write strobes toward the far timer.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_c_control <= `CMR_RST_BYTE;
			timer_c_wr_low <= 1'b0;
			timer_c_wr_high <= 1'b0;
			timer_c_wr_data <= `CMR_RST_BYTE;
		end else begin
			if (wr && paddr == `CMR_TC_CTL)
				timer_c_control <= pwdata[7:0];
			timer_c_wr_low <= wr_tlo;
			timer_c_wr_high <= wr_thi;
			if (tc_wr)
				timer_c_wr_data <= pwdata[7:0];
		end
	end

	// Overflow flag: only true rollovers set it, never a trigger reset.
	// Set wins over a same-cycle clear.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ovf_flag <= 1'b0;
		else if (timer_c_overflow && !timer_c_reset)
			ovf_flag <= 1'b1;
		else if (wr_st && pwdata[`CMR_ST_OVF])
			ovf_flag <= 1'b0;
	end

	// ****************************************************************
	// APB read mux and handshake.
	// ****************************************************************

	// Read data is picked in the setup cycle; unmapped offsets error.
	always @* begin
		next_prdata = `CMR_RST_DATA;
		next_err = 1'b0;
		case (paddr)
			`CMR_ENH_CTL: next_prdata[7:0] = ctl_w[7:0];
			`CMR_STD_CTL: next_prdata[7:0] = ctl_w[15:8];
			`CMR_ENH_DL: next_prdata[7:0] = dat_w[7:0];
			`CMR_ENH_DH: next_prdata[7:0] = dat_w[15:8];
			`CMR_STD_DL: next_prdata[7:0] = dat_w[23:16];
			`CMR_STD_DH: next_prdata[7:0] = dat_w[31:24];
			`CMR_TC_CTL: next_prdata[7:0] = timer_c_control;
			`CMR_TC_LO: next_prdata[7:0] = timer_c_count[7:0];
			`CMR_TC_HI: next_prdata[7:0] = timer_c_count[15:8];
			`CMR_STATUS: next_prdata[2:0] = {ovf_flag, flag_w};
			default: next_err = 1'b1;
		endcase
	end

	// One wait state: pready is high in the second access cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= `CMR_RST_DATA;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (setup) begin
				prdata <= next_prdata;
				pslverr <= next_err;
			end
		end
	end

endmodule // cmr_mode_routing

/* testbench/cmr_timer_model.sv */
// Model of the timers that sit beyond the routing block.
// Assumes one clock shared with the block and counts once per cycle.
module cmr_timer_model (
	input  logic        pclk,
	input  logic        presetn,
	input  logic        timer_a_reset,
	input  logic        timer_c_reset,
	input  logic        timer_c_wr_low,
	input  logic        timer_c_wr_high,
	input  logic [7:0]  timer_c_wr_data,
	output logic [15:0] timer_a_count,
	output logic [15:0] timer_c_count,
	output logic [7:0]  pwm_base_count,
	output logic        timer_c_overflow
);
	timeunit 1ns;
	timeprecision 1ps;
	// Counters run in timer mode on pclk, so every reset pulse is seen.
	// A byte load is applied after the reset, so the written value wins.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_a_count <= 16'h0000;
			timer_c_count <= 16'h0000;
			pwm_base_count <= 8'h00;
			timer_c_overflow <= 1'b0;
		end else begin
			timer_a_count <= timer_a_reset ? 16'h0000 : timer_a_count + 16'h0001;
			pwm_base_count <= pwm_base_count + 8'h01;
			timer_c_overflow <= (timer_c_count == 16'hffff);
			timer_c_count <= timer_c_reset ? 16'h0000 : timer_c_count + 16'h0001;
			if (timer_c_wr_low)
				timer_c_count[7:0] <= timer_c_wr_data;
			if (timer_c_wr_high)
				timer_c_count[15:8] <= timer_c_wr_data;
		end
	end
endmodule // cmr_timer_model

/* testbench/cmr_chk.sv */
// Checker of the routing block, bound to its top module.
// Assumes the single pclk domain and the asynchronous presetn.
module cmr_chk (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        adc_enabled,
	input logic        timer_a_reset,
	input logic        timer_c_reset,
	input logic        timer_c_wr_low,
	input logic        timer_c_wr_high,
	input logic        adc_start
);
	// One domain, so clock and disable are stated once.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	trig_c_pulse_a: assert property (timer_c_reset |=> !timer_c_reset)
		else $error("timer C reset longer than one cycle");
	trig_a_pulse_a: assert property (timer_a_reset |=> !timer_a_reset)
		else $error("timer A reset longer than one cycle");
	adc_gate_a: assert property (adc_start |-> $past(adc_enabled))
		else $error("conversion started while converter disabled");
	adc_pair_a: assert property (adc_start |-> timer_a_reset || timer_c_reset)
		else $error("conversion start without a timer reset");
	write_wins_a: assert property (timer_c_wr_low || timer_c_wr_high |-> !timer_c_reset)
		else $error("timer reset beside a timer write");
	write_cause_a: assert property (timer_c_wr_low |->
		$past(psel && penable && pready && pwrite && paddr == 8'h1c))
		else $error("timer low load without a bus write");
	ctl_upper_a: assert property (pready && paddr[7:3] == 5'h00 |-> prdata[7:6] == 2'b00)
		else $error("control upper bits not zero");
	apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
		else $error("bus answer not after one wait state");
endmodule // cmr_chk

/* testbench/tb_top.sv */
// Self-checking bench of the routing block with a timer model.
// Assumes the block answers APB after one wait state.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, adc_enabled, pready, pslverr;
	logic        timer_a_reset, timer_c_reset, timer_c_wr_low, timer_c_wr_high;
	logic        adc_start, timer_c_overflow;
	logic [7:0]  paddr, pwm_base_count, timer_c_wr_data, timer_c_control;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] timer_a_count, timer_c_count;
	logic [1:0]  unit_pin;
	logic [32:0] exp_q[$];
	logic [7:0]  wr_q[$];
	int          fails, checks, cyc;
	cmr_mode_routing uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_a_count(timer_a_count), .timer_c_count(timer_c_count),
		.pwm_base_count(pwm_base_count), .timer_c_overflow(timer_c_overflow),
		.adc_enabled(adc_enabled), .capture_in(2'b00), .unit_pin(unit_pin),
		.timer_a_reset(timer_a_reset), .timer_c_reset(timer_c_reset),
		.timer_c_wr_low(timer_c_wr_low), .timer_c_wr_high(timer_c_wr_high),
		.timer_c_wr_data(timer_c_wr_data), .timer_c_control(timer_c_control),
		.adc_start(adc_start));
	cmr_timer_model tmr (.pclk(pclk), .presetn(presetn), .timer_a_reset(timer_a_reset),
		.timer_c_reset(timer_c_reset), .timer_c_wr_low(timer_c_wr_low),
		.timer_c_wr_high(timer_c_wr_high), .timer_c_wr_data(timer_c_wr_data),
		.timer_a_count(timer_a_count), .timer_c_count(timer_c_count),
		.pwm_base_count(pwm_base_count), .timer_c_overflow(timer_c_overflow));
	// ****************************************************************
	// Clock, timeout and the shared comparison.
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
		checks++;
		if (seen !== ex) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// The run needs about 520 cycles; the ceiling leaves a wide margin.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict;
		end
	end
	// Reads complete here; the oldest note holds the expected {error, word}.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk("read word", {pslverr, prdata}, exp_q.pop_front());
	end
	// Each load pulse toward timer C must carry the byte that software wrote.
	always @(posedge pclk) begin
		if (timer_c_wr_low || timer_c_wr_high)
			chk("timer load byte", timer_c_wr_data, wr_q.pop_front());
	end
	// One bus transfer; the request is held until pready is sampled high.
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		if (!w)
			exp_q.push_back(e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (!pready && ++n < 50);
		// A missing answer is a failure, not a silent release.
		if (!pready)
			fails++;
		{psel, penable} <= 2'b00;
	endtask
	// Arms one unit in trigger mode just ahead of its timer and waits for the trigger.
	task automatic trig(input logic [7:0] u, input logic [7:0] asg, input bit en,
		input bit use_c, input bit adc);
		logic [15:0] v;
		logic        rc, ra, ad;
		int          n;
		adc_enabled <= en;
		apb(1, 8'h18, {24'h0, asg}, 33'h0);
		v = (use_c ? timer_c_count : timer_a_count) + 16'd60;
		apb(1, 8'h08 + u * 8, {24'h0, v[7:0]}, 33'h0);
		apb(1, 8'h0c + u * 8, {24'h0, v[15:8]}, 33'h0);
		apb(1, u * 4, 32'h0b, 33'h0);
		{rc, ra, ad, n} = 0;
		while (!rc && !ra && n < 300) begin
			@(posedge pclk);
			#1;
			{rc, ra, ad} = {timer_c_reset, timer_a_reset, adc_start};
			n++;
		end
		chk("timer C reset", rc, use_c);
		chk("timer A reset", ra, !use_c);
		chk("conversion start", ad, adc);
		chk("unit pin", unit_pin, 2'b00);
		apb(0, 8'h24, 0, 33'h1 << u);
		apb(1, u * 4, 0, 33'h0);
		apb(1, 8'h24, 32'h7, 33'h0);
		$display("test trigger unit %0d assign %h done", u, asg);
	endtask
	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata, adc_enabled, presetn} = 0;
		r = $urandom(32'hd5e97452);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0, 33'h0);
		apb(1, 8'h00, 32'hff, 33'h0);
		apb(0, 8'h00, 0, 33'h3f);
		apb(1, 8'h00, 0, 33'h0);
		r = $urandom;
		apb(1, 8'h10, r, 33'h0);
		apb(1, 8'h14, r >> 8, 33'h0);
		apb(0, 8'h10, 0, {25'h0, r[7:0]});
		apb(0, 8'h14, 0, {25'h0, r[15:8]});
		apb(0, 8'h28, 0, {1'b1, 32'h0});
		$display("test registers done");
		wr_q.push_back(8'h12);
		apb(1, 8'h20, 32'h12, 33'h0);
		wr_q.push_back(8'h00);
		apb(1, 8'h1c, 32'h0, 33'h0);
		apb(0, 8'h20, 0, 33'h12);
		$display("test timer load done");
		trig(0, 8'h08, 1, 1, 1);
		trig(0, 8'h00, 1, 0, 1);
		trig(0, 8'h40, 0, 1, 0);
		trig(1, 8'h40, 1, 1, 0);
		trig(1, 8'h08, 1, 0, 0);
		trig(1, 8'h00, 1, 0, 0);
		repeat (2) @(posedge pclk);
		print_verdict;
	end
endmodule // tb_top
bind cmr_mode_routing cmr_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.adc_enabled(adc_enabled), .timer_a_reset(timer_a_reset), .timer_c_reset(timer_c_reset),
	.timer_c_wr_low(timer_c_wr_low), .timer_c_wr_high(timer_c_wr_high),
	.adc_start(adc_start));
